// ==== oajag_defines.vh ====
// Purpose: Constants for the operand and jump address generator
// Assumes: 15-bit program counter, 8-bit data pointers
// Notes:   Included by both design files
`ifndef OAJAG_DEFINES_VH
`define OAJAG_DEFINES_VH

// ********************
// Operation codes
// ********************
`define OAJAG_OP_NONE      4'h0
`define OAJAG_OP_DIRECT    4'h1
`define OAJAG_OP_IND       4'h2
`define OAJAG_OP_IND_INC   4'h3
`define OAJAG_OP_IND_DEC   4'h4
`define OAJAG_OP_IMM       4'h5
`define OAJAG_OP_IMM_SHORT 4'h6
`define OAJAG_OP_TABLE     4'h7
`define OAJAG_OP_REL_JUMP  4'h8
`define OAJAG_OP_ABS_JUMP  4'h9
`define OAJAG_OP_LONG_JUMP 4'hA
`define OAJAG_OP_IND_JUMP  4'hB
`define OAJAG_OP_VEC_JUMP  4'hC
`define OAJAG_OP_REG       4'hD
`define OAJAG_OP_BIT       4'hE

// ********************
// Field layout
// ********************
`define OAJAG_PC_W         15
`define OAJAG_ABS_W        12
`define OAJAG_REL_W        6
`define OAJAG_REG_BASE     4'hF
`define OAJAG_HI_ZERO      4'h0
`define OAJAG_PC_RESET     15'h0000
`define OAJAG_BYTE_RESET   8'h00

// ********************
// Sequencer states
// ********************
`define OAJAG_ST_IDLE      2'h0
`define OAJAG_ST_FETCH1    2'h1
`define OAJAG_ST_FETCH2    2'h2

`endif

// ==== oajag_ptr_unit.v ====
// Purpose: One index pointer with load and post-modify
// Assumes: Same clock as the sequencer
// Notes:   Wraps modulo 256
`timescale 1ns/1ns
`include "oajag_defines.vh"

module oajag_ptr_unit (
    input  wire       core_clk_in,
    input  wire       rst_n_in,
    input  wire       load_in,
    input  wire [7:0] load_val_in,
    input  wire       inc_in,
    input  wire       dec_in,
    output wire [7:0] ptr_out
);
    reg [7:0] ptr_reg;
    reg [7:0] ptr_next;

    always @* begin
        ptr_next = ptr_reg;
        if (load_in) begin
            ptr_next = load_val_in;
        end else if (inc_in) begin
            ptr_next = ptr_reg + 8'h01; // Carry is dropped
        end else if (dec_in) begin
            ptr_next = ptr_reg - 8'h01;
        end
    end

    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ptr_reg <= `OAJAG_BYTE_RESET;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    assign ptr_out = ptr_reg;
endmodule

// ==== oajag_core.v ====
// Operation
// - Direct mode takes data address from the instruction byte.
// - Indirect mode uses selected pointer value as data address.
// - Post-modify accesses at pointer then steps pointer by one.
// - Post-modify only for indirect load and exchange.
// - Immediate operand fetched from program byte after opcode.
// - Short immediate writes nibble into pointer low, clears high.
// - Table load swaps accumulator into pc low, fetches, restores.
// - Program counter is fifteen bits in two bytes.
// - Relative jump adds signed six-bit displacement, -32 to +31.
// - Absolute jump replaces low twelve bits, keeps upper three.
// - Long jump loads all fifteen bits from operand bytes.
// - Indirect jump reads byte at accumulator, loads pc low.
// - Vectored jump reads two adjacent bytes into program counter.
// - Most single-byte operations complete in one cycle.
// - Any single bit of data memory can be set, cleared, tested.
// - Register operands address data F0 to FF.
//
// Purpose: Operand and jump address generation for an 8-bit core
// Assumes: Program memory answers within the cycle its address is presented
// Notes:   Opcode decoding is done upstream; op_in is pre-decoded
`timescale 1ns/1ns
`include "oajag_defines.vh"

module oajag_core (
    input  wire                   core_clk_in,
    input  wire                   rst_n_in,
    input  wire                   start_in,
    input  wire [3:0]             op_in,
    input  wire                   ptr_sel_in,
    input  wire [7:0]             field_in,
    input  wire [11:0]            abs_in,
    input  wire [2:0]             bit_in,
    input  wire                   bit_val_in,
    input  wire [7:0]             acc_in,
    input  wire [7:0]             pmem_data_in,
    input  wire [7:0]             dmem_rdata_in,
    output wire                   busy_out,
    output reg                    done_out,
    output reg  [`OAJAG_PC_W-1:0] pc_out,
    output reg  [`OAJAG_PC_W-1:0] pmem_addr_out,
    output reg                    pmem_rd_out,
    output reg  [7:0]             dmem_addr_out,
    output reg                    dmem_en_out,
    output reg  [7:0]             operand_out,
    output reg                    operand_valid_out,
    output reg  [7:0]             acc_load_out,
    output reg                    acc_load_valid_out,
    output reg  [7:0]             bit_wdata_out,
    output reg                    bit_test_out,
    output wire [7:0]             ptr_b_out,
    output wire [7:0]             ptr_x_out
);
    // ********************
    // State
    // ********************
    localparam ST_IDLE   = `OAJAG_ST_IDLE;
    localparam ST_FETCH1 = `OAJAG_ST_FETCH1;
    localparam ST_FETCH2 = `OAJAG_ST_FETCH2;

    reg [1:0]             state_reg;
    reg [1:0]             state_next;
    reg [3:0]             op_reg;
    reg [7:0]             byte1_reg;
    reg [`OAJAG_PC_W-1:0] pc_next;
    reg [`OAJAG_PC_W-1:0] pmem_addr_next;
    reg                   pmem_rd_next;
    reg [7:0]             dmem_addr_next;
    reg                   dmem_en_next;
    reg [7:0]             operand_next;
    reg                   operand_valid_next;
    reg [7:0]             acc_load_next;
    reg                   acc_load_valid_next;
    reg [7:0]             bit_wdata_next;
    reg                   bit_test_next;
    reg                   done_next;
    reg [3:0]             op_next;
    reg [7:0]             byte1_next;
    reg [1:0]             ld_sel;
    reg [1:0]             inc_sel;
    reg [1:0]             dec_sel;
    reg [7:0]             ld_val;
    wire [7:0]            ptr_cur;
    wire [`OAJAG_PC_W-1:0] rel_ext;
    wire [`OAJAG_PC_W-1:0] pc_seq;
    wire [7:0]            bit_mask;
    wire [7:0]            ptr_vals_w [0:1];

    assign ptr_cur     = ptr_sel_in ? ptr_x_out : ptr_b_out;
    // Sign extension of the six-bit displacement
    assign rel_ext = {{(`OAJAG_PC_W-`OAJAG_REL_W){field_in[`OAJAG_REL_W-1]}},
                      field_in[`OAJAG_REL_W-1:0]};
    assign pc_seq   = pc_out + 15'h0001;
    assign bit_mask = 8'h01 << bit_in;
    assign busy_out = (state_reg != ST_IDLE);

    // ********************
    // Index pointers
    // ********************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ptr
            oajag_ptr_unit u_ptr (
                .core_clk_in (core_clk_in),
                .rst_n_in    (rst_n_in),
                .load_in     (ld_sel[gi]),
                .load_val_in (ld_val),
                .inc_in      (inc_sel[gi]),
                .dec_in      (dec_sel[gi]),
                .ptr_out     (ptr_vals_w[gi])
            );
        end
    endgenerate
    assign ptr_b_out = ptr_vals_w[0];
    assign ptr_x_out = ptr_vals_w[1];

    // ********************
    // Decode and sequence
    // ********************
    always @* begin
        state_next          = state_reg;
        op_next             = op_reg;
        byte1_next          = byte1_reg;
        pc_next             = pc_out;
        pmem_addr_next      = pmem_addr_out;
        pmem_rd_next        = 1'b0;
        dmem_addr_next      = dmem_addr_out;
        dmem_en_next        = 1'b0;
        operand_next        = operand_out;
        operand_valid_next  = 1'b0;
        acc_load_next       = acc_load_out;
        acc_load_valid_next = 1'b0;
        bit_wdata_next      = bit_wdata_out;
        bit_test_next       = bit_test_out;
        done_next           = 1'b0;
        ld_sel              = 2'b00;
        inc_sel             = 2'b00;
        dec_sel             = 2'b00;
        ld_val              = {`OAJAG_HI_ZERO, field_in[3:0]};
        case (state_reg)
            ST_IDLE: begin
                if (start_in) begin
                    op_next = op_in;
                    case (op_in)
                        `OAJAG_OP_DIRECT: begin
                            dmem_addr_next = field_in;
                            dmem_en_next   = 1'b1;
                            pc_next        = pc_seq;
                            done_next      = 1'b1;
                        end
                        `OAJAG_OP_IND: begin
                            dmem_addr_next = ptr_cur;
                            dmem_en_next   = 1'b1;
                            pc_next        = pc_seq;
                            done_next      = 1'b1;
                        end
                        `OAJAG_OP_IND_INC, `OAJAG_OP_IND_DEC: begin
                            // Only load/exchange decode to these codes
                            dmem_addr_next = ptr_cur;
                            dmem_en_next   = 1'b1;
                            inc_sel[ptr_sel_in] = (op_in == `OAJAG_OP_IND_INC);
                            dec_sel[ptr_sel_in] = (op_in == `OAJAG_OP_IND_DEC);
                            pc_next        = pc_seq;
                            done_next      = 1'b1;
                        end
                        `OAJAG_OP_IMM_SHORT: begin
                            ld_sel[0] = 1'b1;
                            pc_next   = pc_seq;
                            done_next = 1'b1;
                        end
                        `OAJAG_OP_REG: begin
                            dmem_addr_next = {`OAJAG_REG_BASE, field_in[3:0]};
                            dmem_en_next   = 1'b1;
                            pc_next        = pc_seq;
                            done_next      = 1'b1;
                        end
                        `OAJAG_OP_BIT: begin
                            // Read-modify-write on any data address
                            dmem_addr_next = field_in;
                            dmem_en_next   = 1'b1;
                            state_next     = ST_FETCH1;
                        end
                        `OAJAG_OP_REL_JUMP: begin
                            // Caller never issues +1 here
                            pc_next   = pc_out + rel_ext;
                            done_next = 1'b1;
                        end
                        `OAJAG_OP_ABS_JUMP: begin
                            pc_next   = {pc_out[`OAJAG_PC_W-1:`OAJAG_ABS_W], abs_in};
                            done_next = 1'b1;
                        end
                        `OAJAG_OP_IMM, `OAJAG_OP_LONG_JUMP, `OAJAG_OP_VEC_JUMP: begin
                            pmem_addr_next = pc_seq;
                            pmem_rd_next   = 1'b1;
                            state_next     = ST_FETCH1;
                        end
                        `OAJAG_OP_TABLE, `OAJAG_OP_IND_JUMP: begin
                            // Accumulator stands in for the low pc byte
                            pmem_addr_next = {pc_out[`OAJAG_PC_W-1:8], acc_in};
                            pmem_rd_next   = 1'b1;
                            state_next     = ST_FETCH1;
                        end
                        default: begin
                            pc_next   = pc_seq;
                            done_next = 1'b1;
                        end
                    endcase
                end
            end
            ST_FETCH1: begin
                case (op_reg)
                    `OAJAG_OP_IMM: begin
                        operand_next       = pmem_data_in;
                        operand_valid_next = 1'b1;
                        pc_next            = pc_out + 15'h0002;
                        done_next          = 1'b1;
                        state_next         = ST_IDLE;
                    end
                    `OAJAG_OP_TABLE: begin
                        // Low byte never changed, so it is restored by design
                        acc_load_next       = pmem_data_in;
                        acc_load_valid_next = 1'b1;
                        pc_next             = pc_seq;
                        done_next           = 1'b1;
                        state_next          = ST_IDLE;
                    end
                    `OAJAG_OP_IND_JUMP: begin
                        pc_next    = {pc_out[`OAJAG_PC_W-1:8], pmem_data_in};
                        done_next  = 1'b1;
                        state_next = ST_IDLE;
                    end
                    `OAJAG_OP_BIT: begin
                        bit_test_next  = |(dmem_rdata_in & bit_mask);
                        bit_wdata_next = bit_val_in ? (dmem_rdata_in | bit_mask)
                                                    : (dmem_rdata_in & ~bit_mask);
                        pc_next        = pc_seq;
                        done_next      = 1'b1;
                        state_next     = ST_IDLE;
                    end
                    `OAJAG_OP_LONG_JUMP, `OAJAG_OP_VEC_JUMP: begin
                        byte1_next     = pmem_data_in;
                        pmem_addr_next = pmem_addr_out + 15'h0001;
                        pmem_rd_next   = 1'b1;
                        state_next     = ST_FETCH2;
                    end
                    default: begin
                        state_next = ST_IDLE;
                    end
                endcase
            end
            ST_FETCH2: begin
                // Upper byte first; its top bit is unused
                pc_next    = {byte1_reg[6:0], pmem_data_in};
                done_next  = 1'b1;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ********************
    // Registers
    // ********************
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_reg          <= ST_IDLE;
            op_reg             <= `OAJAG_OP_NONE;
            byte1_reg          <= `OAJAG_BYTE_RESET;
            pc_out             <= `OAJAG_PC_RESET;
            pmem_addr_out      <= `OAJAG_PC_RESET;
            pmem_rd_out        <= 1'b0;
            dmem_addr_out      <= `OAJAG_BYTE_RESET;
            dmem_en_out        <= 1'b0;
            operand_out        <= `OAJAG_BYTE_RESET;
            operand_valid_out  <= 1'b0;
            acc_load_out       <= `OAJAG_BYTE_RESET;
            acc_load_valid_out <= 1'b0;
            bit_wdata_out      <= `OAJAG_BYTE_RESET;
            bit_test_out       <= 1'b0;
            done_out           <= 1'b0;
        end else begin
            state_reg          <= state_next;
            op_reg             <= op_next;
            byte1_reg          <= byte1_next;
            pc_out             <= pc_next;
            pmem_addr_out      <= pmem_addr_next;
            pmem_rd_out        <= pmem_rd_next;
            dmem_addr_out      <= dmem_addr_next;
            dmem_en_out        <= dmem_en_next;
            operand_out        <= operand_next;
            operand_valid_out  <= operand_valid_next;
            acc_load_out       <= acc_load_next;
            acc_load_valid_out <= acc_load_valid_next;
            bit_wdata_out      <= bit_wdata_next;
            bit_test_out       <= bit_test_next;
            done_out           <= done_next;
        end
    end
endmodule

// ==== oajag_mem_model.sv ====
// Purpose: Program and data memory seen by the address generator
// Assumes: Reads answer within the cycle the address is presented
// Notes:   Outside a read the data lines change every cycle
`timescale 1ns/1ns

module oajag_mem_model (
    input  wire        core_clk_in,
    input  wire [14:0] pmem_addr_in,
    input  wire        pmem_rd_in,
    input  wire [7:0]  dmem_addr_in,
    input  wire        dmem_en_in,
    output wire [7:0]  pmem_data_out,
    output wire [7:0]  dmem_rdata_out
);
    // Junk pattern so a late sample never sees a stale good byte
    reg [7:0] junk_reg = 8'h5C;

    always @(posedge core_clk_in) begin
        junk_reg <= junk_reg + 8'h3B;
    end

    assign pmem_data_out  = pmem_rd_in ? (pmem_addr_in[7:0] ^ {1'b0, pmem_addr_in[14:8]} ^ 8'hA5)
                                       : junk_reg;
    assign dmem_rdata_out = dmem_en_in ? (dmem_addr_in ^ 8'hC3) : ~junk_reg;
endmodule

// ==== oajag_core_monitor.sv ====
// Purpose: Port checker for the address generator
// Assumes: A request is taken when start is high and busy is low
// Notes:   Bound from the testbench top
`timescale 1ns/1ns
`include "oajag_defines.vh"

module oajag_core_monitor (
    input wire        core_clk_in,
    input wire        rst_n_in,
    input wire        start_in,
    input wire [3:0]  op_in,
    input wire        ptr_sel_in,
    input wire [7:0]  field_in,
    input wire [11:0] abs_in,
    input wire [7:0]  acc_in,
    input wire        busy_out,
    input wire        done_out,
    input wire [14:0] pc_out,
    input wire [14:0] pmem_addr_out,
    input wire        pmem_rd_out,
    input wire [7:0]  dmem_addr_out,
    input wire        dmem_en_out,
    input wire        operand_valid_out,
    input wire        acc_load_valid_out,
    input wire [7:0]  ptr_b_out,
    input wire [7:0]  ptr_x_out
);
    wire        take    = start_in && !busy_out;
    wire [7:0]  sel_ptr = ptr_sel_in ? ptr_x_out : ptr_b_out;
    wire [14:0] rel_tgt = pc_out + {{9{field_in[5]}}, field_in[5:0]};

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_imm_fetch;
        pmem_rd_out && pmem_addr_out == $past(pc_out) + 15'h0001 ##1 operand_valid_out && done_out;
    endsequence
    sequence s_table_fetch;
        pmem_addr_out == {$past(pc_out[14:8]), $past(acc_in)} ##1 acc_load_valid_out && done_out;
    endsequence

    a_direct_addr: assert property (take && op_in == `OAJAG_OP_DIRECT |=> dmem_en_out &&
        dmem_addr_out == $past(field_in) && done_out) else $error("direct address wrong");
    a_ind_addr: assert property (take && op_in == `OAJAG_OP_IND |=> dmem_en_out &&
        dmem_addr_out == $past(sel_ptr)) else $error("indirect address wrong");
    a_post_inc: assert property (take && op_in == `OAJAG_OP_IND_INC |=>
        ($past(ptr_sel_in) ? ptr_x_out : ptr_b_out) == $past(sel_ptr) + 8'h01)
        else $error("pointer not stepped up");
    a_post_dec: assert property (take && op_in == `OAJAG_OP_IND_DEC |=>
        ($past(ptr_sel_in) ? ptr_x_out : ptr_b_out) == $past(sel_ptr) - 8'h01)
        else $error("pointer not stepped down");
    a_short_load: assert property (take && op_in == `OAJAG_OP_IMM_SHORT |=>
        ptr_b_out == {`OAJAG_HI_ZERO, $past(field_in[3:0])}) else $error("short load wrong");
    a_rel_jump: assert property (take && op_in == `OAJAG_OP_REL_JUMP |=>
        pc_out == $past(rel_tgt)) else $error("relative target wrong");
    a_abs_jump: assert property (take && op_in == `OAJAG_OP_ABS_JUMP |=>
        pc_out == {$past(pc_out[14:12]), $past(abs_in)}) else $error("absolute target wrong");
    a_imm_fetch: assert property (take && op_in == `OAJAG_OP_IMM |=> s_imm_fetch)
        else $error("immediate fetch wrong");
    a_table_fetch: assert property (take && op_in == `OAJAG_OP_TABLE |=> s_table_fetch)
        else $error("table fetch wrong");
    a_long_done: assert property (take && (op_in == `OAJAG_OP_LONG_JUMP ||
        op_in == `OAJAG_OP_VEC_JUMP) |=> !done_out [*2] ##1 done_out)
        else $error("long jump time");
    a_reg_addr: assert property (take && op_in == `OAJAG_OP_REG |=>
        dmem_addr_out == {`OAJAG_REG_BASE, $past(field_in[3:0])}) else $error("register address");
endmodule

// ==== operand_and_jump_address_gen_tb_top.sv ====
// Purpose: Self-checking bench for the address generator
// Assumes: Inputs change on the falling edge
// Notes:   Expected bytes come from the bench's own memory formula
`timescale 1ns/1ns
`include "oajag_defines.vh"

module operand_and_jump_address_gen_tb_top;
    reg         core_clk_in = 1'b0;
    reg         rst_n_in    = 1'b0;
    reg         start_in    = 1'b0;
    reg         ptr_sel_in  = 1'b0;
    reg         bit_val_in  = 1'b0;
    reg  [3:0]  op_in       = 4'h0;
    reg  [7:0]  field_in    = 8'h00;
    reg  [11:0] abs_in      = 12'h000;
    reg  [2:0]  bit_in      = 3'h0;
    reg  [7:0]  acc_in      = 8'h00;
    wire [7:0]  pmem_data_in, dmem_rdata_in, dmem_addr_out, operand_out, acc_load_out;
    wire [7:0]  bit_wdata_out, ptr_b_out, ptr_x_out;
    wire [14:0] pc_out, pmem_addr_out;
    wire        busy_out, done_out, pmem_rd_out, dmem_en_out;
    wire        operand_valid_out, acc_load_valid_out, bit_test_out;
    integer     error_cnt   = 0;
    integer     compares    = 0;
    reg  [7:0]  lat, da, tu;
    reg  [14:0] pa, ep;

    oajag_core i_oajag_core (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .start_in(start_in), .op_in(op_in), .ptr_sel_in(ptr_sel_in), .field_in(field_in),
        .abs_in(abs_in), .bit_in(bit_in), .bit_val_in(bit_val_in), .acc_in(acc_in),
        .pmem_data_in(pmem_data_in), .dmem_rdata_in(dmem_rdata_in), .busy_out(busy_out),
        .done_out(done_out), .pc_out(pc_out), .pmem_addr_out(pmem_addr_out),
        .pmem_rd_out(pmem_rd_out), .dmem_addr_out(dmem_addr_out), .dmem_en_out(dmem_en_out),
        .operand_out(operand_out), .operand_valid_out(operand_valid_out),
        .acc_load_out(acc_load_out), .acc_load_valid_out(acc_load_valid_out),
        .bit_wdata_out(bit_wdata_out), .bit_test_out(bit_test_out),
        .ptr_b_out(ptr_b_out), .ptr_x_out(ptr_x_out));
    oajag_mem_model i_oajag_mem_model (.core_clk_in(core_clk_in), .pmem_addr_in(pmem_addr_out),
        .pmem_rd_in(pmem_rd_out), .dmem_addr_in(dmem_addr_out), .dmem_en_in(dmem_en_out),
        .pmem_data_out(pmem_data_in), .dmem_rdata_out(dmem_rdata_in));

    initial begin
        forever #25 core_clk_in = ~core_clk_in;
    end

    // Addresses latched just after the edge, clear of the driving edge
    always @(posedge core_clk_in) begin
        #1;
        if (dmem_en_out === 1'b1)
            da = dmem_addr_out;
        if (pmem_rd_out === 1'b1)
            pa = pmem_addr_out;
    end

    function [7:0] pb(input [14:0] a);
        pb = a[7:0] ^ {1'b0, a[14:8]} ^ 8'hA5;
    endfunction

    task cmp_byte(input [7:0] got, input [7:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task cmp_pc(input [14:0] got, input [14:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task end_of_test;
        begin
            if (error_cnt == 0 && compares > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask

    task do_reset;
        begin
            rst_n_in = 1'b0;
            repeat (20) @(negedge core_clk_in);
            rst_n_in = 1'b1;
            @(negedge core_clk_in);
        end
    endtask

    // One request; returns on the falling edge where done is seen
    task issue(input [3:0] op, input sel, input [7:0] fld, input [11:0] ab, input [7:0] acc);
        begin
            // Let an edge pass so start never drops and rises in one time step
            @(negedge core_clk_in);
            op_in = op;
            ptr_sel_in = sel;
            field_in = fld;
            abs_in = ab;
            acc_in = acc;
            start_in = 1'b1;
            @(negedge core_clk_in);
            start_in = 1'b0;
            lat = 8'h01;
            while (done_out !== 1'b1 && lat < 8'h08) begin
                @(negedge core_clk_in);
                lat = lat + 8'h01;
            end
        end
    endtask

    task t_jumps;
        begin
            cmp_pc(pc_out, `OAJAG_PC_RESET);
            issue(`OAJAG_OP_ABS_JUMP, 1'b0, 8'h00, 12'h125, 8'h00);
            cmp_pc(pc_out, 15'h0125);
            cmp_byte(lat, 8'h01);
            issue(`OAJAG_OP_REL_JUMP, 1'b0, 8'h0A, 12'h000, 8'h00);
            cmp_pc(pc_out, 15'h012F);
            issue(`OAJAG_OP_REL_JUMP, 1'b0, 8'h21, 12'h000, 8'h00);
            cmp_pc(pc_out, 15'h0110);
            issue(`OAJAG_OP_LONG_JUMP, 1'b0, 8'h00, 12'h000, 8'h00);
            tu = pb(15'h0111);
            ep = {tu[6:0], pb(15'h0112)};
            cmp_pc(pc_out, ep);
            issue(`OAJAG_OP_ABS_JUMP, 1'b0, 8'h00, 12'hABC, 8'h00);
            ep = {ep[14:12], 12'hABC};
            cmp_pc(pc_out, ep);
            issue(`OAJAG_OP_IND_JUMP, 1'b0, 8'h00, 12'h000, 8'h26);
            cmp_pc(pa, {ep[14:8], 8'h26});
            ep = {ep[14:8], pb({ep[14:8], 8'h26})};
            cmp_pc(pc_out, ep);
            issue(`OAJAG_OP_VEC_JUMP, 1'b0, 8'h00, 12'h000, 8'h00);
            tu = pb(ep + 15'h0001);
            ep = {tu[6:0], pb(ep + 15'h0002)};
            cmp_pc(pc_out, ep);
            cmp_byte(lat, 8'h03);
            cmp_byte({7'h00, busy_out}, 8'h00);
            issue(`OAJAG_OP_TABLE, 1'b0, 8'h00, 12'h000, 8'h1F);
            cmp_byte(acc_load_out, pb({ep[14:8], 8'h1F}));
            cmp_pc(pc_out, ep + 15'h0001);
            ep = ep + 15'h0001;
            issue(`OAJAG_OP_IMM, 1'b0, 8'h00, 12'h000, 8'h00);
            cmp_byte(operand_out, pb(ep + 15'h0001));
            cmp_pc(pc_out, ep + 15'h0002);
            issue(`OAJAG_OP_NONE, 1'b0, 8'h00, 12'h000, 8'h00);
            cmp_pc(pc_out, ep + 15'h0003);
            cmp_byte(lat, 8'h01);
        end
    endtask

    task t_operands;
        begin
            issue(`OAJAG_OP_IND_DEC, 1'b0, 8'h00, 12'h000, 8'h00);
            cmp_byte(ptr_b_out, 8'hFF);
            issue(`OAJAG_OP_IMM_SHORT, 1'b0, 8'hA7, 12'h000, 8'h00);
            cmp_byte(ptr_b_out, 8'h07);
            issue(`OAJAG_OP_IND, 1'b0, 8'h00, 12'h000, 8'h00);
            cmp_byte(ptr_b_out, 8'h07);
            issue(`OAJAG_OP_IND_INC, 1'b0, 8'h00, 12'h000, 8'h00);
            cmp_byte(da, 8'h07);
            cmp_byte(ptr_b_out, 8'h08);
            issue(`OAJAG_OP_IND_DEC, 1'b1, 8'h00, 12'h000, 8'h00);
            cmp_byte(ptr_x_out, 8'hFF);
            issue(`OAJAG_OP_IND_INC, 1'b1, 8'h00, 12'h000, 8'h00);
            cmp_byte(da, 8'hFF);
            cmp_byte(ptr_x_out, 8'h00);
            issue(`OAJAG_OP_REG, 1'b0, 8'h0C, 12'h000, 8'h00);
            cmp_byte(da, 8'hFC);
            bit_in = 3'h3;
            bit_val_in = 1'b1;
            issue(`OAJAG_OP_BIT, 1'b0, 8'h05, 12'h000, 8'h00);
            cmp_byte(bit_wdata_out, 8'hCE);
            cmp_byte({7'h00, bit_test_out}, 8'h00);
            bit_in = 3'h2;
            bit_val_in = 1'b0;
            issue(`OAJAG_OP_BIT, 1'b0, 8'h05, 12'h000, 8'h00);
            cmp_byte(bit_wdata_out, 8'hC2);
            cmp_byte({7'h00, bit_test_out}, 8'h01);
            issue(`OAJAG_OP_DIRECT, 1'b0, 8'h05, 12'h000, 8'h00);
            cmp_byte(da, 8'h05);
        end
    endtask

    initial begin
        do_reset;
        t_jumps;
        do_reset;
        t_operands;
        end_of_test;
    end

    // Whole run is under a hundred cycles; this leaves wide margin
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        end_of_test;
    end
endmodule

bind oajag_core oajag_core_monitor i_oajag_core_monitor (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .start_in(start_in), .op_in(op_in), .ptr_sel_in(ptr_sel_in),
    .field_in(field_in), .abs_in(abs_in), .acc_in(acc_in), .busy_out(busy_out),
    .done_out(done_out), .pc_out(pc_out), .pmem_addr_out(pmem_addr_out),
    .pmem_rd_out(pmem_rd_out), .dmem_addr_out(dmem_addr_out), .dmem_en_out(dmem_en_out),
    .operand_valid_out(operand_valid_out), .acc_load_valid_out(acc_load_valid_out),
    .ptr_b_out(ptr_b_out), .ptr_x_out(ptr_x_out));
